// ### rtl/rx_init_align.sv
`timescale 1ns/1ps
// Notes on behaviour
// (R1) host holds pll reset at least 10 ns
// (R2) data usable only after stable pll lock
// (R3) host keeps phase reset until pll locked
// (R4) each channel picks its own phase tap
// (R5) old parts: fifo held reset until lock
// (R6) new parts: lock after counted data transitions
// (R7) host resets fifo only after phase lock
// (R8) old parts: tap change drops lock flag
// (R9) new parts: lock sticky until reset
// (R10) phase reset clears training, forces retrain
// (R11) fifo reset clears fifo, keeps tap
// (R12) old parts: fifo reset leaves lock flag
// (R13) per-channel slip pulse moves word boundary
// (R14) slip reset works anytime, independently
// (R15) host sets rollover limit at least factor
// (R16) host slips until control character seen
// (R17) default boundary fixed after pll reset
// (R18) host issues fixed slip count otherwise
// (R19) host asserts pll and phase reset together
// (R20) far side sends transitions; host awaits lock
// (R21) new parts: host pulses fifo reset after lock
// (R22) host pulses slip reset before slip pulses
// (R23) ready only when every channel aligned
// (R24) one slip pulse equals one bit, wraps
// (R25) host rounds reset time up, debounces lock
module rx_init_align #(
    parameter int NUM_CH = rx_init_pkg::NUM_CH_DEF,
    parameter int DES_FACTOR = rx_init_pkg::DES_FACTOR_DEF,
    parameter int LIMIT_W = $clog2(DES_FACTOR) + 2,
    parameter int PLL_LOCK_CYCLES = rx_init_pkg::PLL_LOCK_CYCLES_DEF,
    parameter int TRANS_COUNT = rx_init_pkg::TRANS_COUNT_DEF,
    parameter bit NEW_GEN = 1'b1,
    parameter bit AUTO_FIFO_RST = 1'b1,
    parameter bit TWO_STEP_UNLOCK = 1'b0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic pll_reset,
    input wire logic [NUM_CH-1:0] dpa_reset,
    input wire logic [NUM_CH-1:0] lock_flag_reset,
    input wire logic [NUM_CH-1:0] fifo_reset,
    input wire logic [NUM_CH-1:0] slip_reset,
    input wire logic [NUM_CH-1:0] slip_pulse,
    input wire logic [LIMIT_W-1:0] slip_limit,
    input wire logic [NUM_CH*DES_FACTOR-1:0] serial_word,
    input wire logic [NUM_CH-1:0] phase_early,
    input wire logic [NUM_CH-1:0] phase_late,
    input wire logic [NUM_CH-1:0] boundary_found,
    output logic pll_locked,
    output logic pll_reset_short,
    output logic [NUM_CH-1:0] dpa_locked,
    output logic [NUM_CH*rx_init_pkg::TAP_W-1:0] tap_sel,
    output logic [NUM_CH*DES_FACTOR-1:0] rx_word,
    output logic [NUM_CH-1:0] rx_word_valid,
    output logic [NUM_CH*LIMIT_W-1:0] slip_pos,
    output logic link_ready
);
    localparam int TAP_W = rx_init_pkg::TAP_W;
    localparam int TRANS_W = rx_init_pkg::TRANS_W;
    localparam int RST_LEN_W = rx_init_pkg::RST_LEN_W;
    localparam int LOCK_W = $clog2(PLL_LOCK_CYCLES + 1) + 1;

    // number of bit transitions inside a word, counting the boundary to the previous word
    function automatic logic [TRANS_W-1:0] count_edges(
        input logic [DES_FACTOR-1:0] w,
        input logic prev_msb
    );
        logic [DES_FACTOR-1:0] shifted;
        logic [TRANS_W-1:0] n;
        shifted = {w[DES_FACTOR-2:0], prev_msb};
        n = '0;
        for (int i = 0; i < DES_FACTOR; i++) begin
            n = n + TRANS_W'(w[i] ^ shifted[i]);
        end
        count_edges = n;
    endfunction

    // saturating add so a long training never wraps back below the target
    function automatic logic [TRANS_W-1:0] sat_add(
        input logic [TRANS_W-1:0] a,
        input logic [TRANS_W-1:0] b
    );
        logic [TRANS_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = s[TRANS_W] ? '1 : s[TRANS_W-1:0];
    endfunction

    // ---------------- pll reset and lock model ----------------
    rx_init_pkg::pll_state_t pll_state_reg;  // pll lock progress
    rx_init_pkg::pll_state_t pll_state_next;
    logic [RST_LEN_W-1:0] rst_len_reg;  // cycles the pll reset has been held
    logic [RST_LEN_W-1:0] rst_len_next;
    logic [LOCK_W-1:0] lock_cnt_reg;  // cycles since pll reset release
    logic [LOCK_W-1:0] lock_cnt_next;
    logic short_reg;  // last pll reset pulse was too short
    logic short_next;

    // pll state: a pulse shorter than the least time leaves the pll unlocked
    always_comb begin
        pll_state_next = pll_state_reg;
        rst_len_next = rst_len_reg;
        lock_cnt_next = lock_cnt_reg;
        short_next = short_reg;
        case (pll_state_reg)
            rx_init_pkg::PLL_IN_RESET: begin
                // saturate the length count at its top value
                if (rst_len_reg != '1) begin
                    rst_len_next = rst_len_reg + 1'b1;
                end
                if (!pll_reset) begin
                    lock_cnt_next = '0;
                    if (int'(rst_len_reg) >= rx_init_pkg::PLL_RST_MIN_CYC) begin  // R1
                        pll_state_next = rx_init_pkg::PLL_ACQUIRE;
                        short_next = 1'b0;
                    end else begin
                        // clock phases may be corrupt: refuse to lock until a proper reset
                        pll_state_next = rx_init_pkg::PLL_BAD_RESET;
                        short_next = 1'b1;
                    end
                end
            end
            rx_init_pkg::PLL_ACQUIRE: begin
                if (pll_reset) begin
                    pll_state_next = rx_init_pkg::PLL_IN_RESET;
                    rst_len_next = RST_LEN_W'(1);
                end else if (int'(lock_cnt_reg) >= PLL_LOCK_CYCLES - 1) begin
                    pll_state_next = rx_init_pkg::PLL_LOCKED;
                end else begin
                    lock_cnt_next = lock_cnt_reg + 1'b1;
                end
            end
            rx_init_pkg::PLL_LOCKED, rx_init_pkg::PLL_BAD_RESET: begin
                if (pll_reset) begin
                    pll_state_next = rx_init_pkg::PLL_IN_RESET;
                    rst_len_next = RST_LEN_W'(1);
                end
            end
            default: begin
                pll_state_next = rx_init_pkg::PLL_IN_RESET;
                rst_len_next = '0;
            end
        endcase
    end

    // pll registers; after system reset the pll counts as properly reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pll_state_reg <= rx_init_pkg::PLL_IN_RESET;
            rst_len_reg <= '1;
            lock_cnt_reg <= '0;
            short_reg <= 1'b0;
        end else begin
            pll_state_reg <= pll_state_next;
            rst_len_reg <= rst_len_next;
            lock_cnt_reg <= lock_cnt_next;
            short_reg <= short_next;
        end
    end

    logic pll_ok;  // serdes usable only from here on
    assign pll_ok = (pll_state_reg == rx_init_pkg::PLL_LOCKED);  // R2
    assign pll_locked = pll_ok;
    assign pll_reset_short = short_reg;

    // ---------------- per-channel phase alignment and sync fifo ----------------
    logic [NUM_CH-1:0] aligned_flag;  // boundary found, phase locked and word valid per channel

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        logic [DES_FACTOR-1:0] in_word;  // raw deserialized word of this channel
        logic train_rst;  // whole phase block held in reset
        logic fifo_clr;  // sync fifo held in reset
        logic step_up;  // tap moves later
        logic step_dn;  // tap moves earlier
        logic [DES_FACTOR-1:0] cnt_src;  // stream the transition counter looks at
        logic [TAP_W-1:0] tap_reg;  // selected phase tap
        logic [TAP_W-1:0] tap_next;
        logic [TRANS_W-1:0] trans_reg;  // transitions seen since training start
        logic [TRANS_W-1:0] trans_next;
        logic lock_reg;  // phase-lock flag
        logic lock_next;
        logic ever_reg;  // lock has risen since the last phase reset
        logic ever_next;
        logic last_dir_reg;  // direction of last tap step, 1 = later
        logic last_dir_next;
        logic stepped_reg;  // a tap step has happened since lock
        logic stepped_next;
        logic [DES_FACTOR-1:0] fifo_reg;  // sync fifo stage
        logic [DES_FACTOR-1:0] fifo_next;
        logic [DES_FACTOR-1:0] prev_reg;  // word before the fifo stage, for slipping
        logic [DES_FACTOR-1:0] prev_next;
        logic fifo_v_reg;  // fifo stage holds data
        logic fifo_v_next;
        logic last_msb_reg;  // last bit of previous counted word
        logic last_msb_next;

        assign in_word = serial_word[c*DES_FACTOR +: DES_FACTOR];
        // phase block also waits for the pll; the host should keep its reset anyway
        assign train_rst = dpa_reset[c] || !pll_ok;  // R10 R3
        // old parts may hold the fifo automatically until the first lock
        assign fifo_clr = fifo_reset[c] || train_rst
                          || (AUTO_FIFO_RST && !NEW_GEN && !ever_reg);  // R5 R11
        // new parts count on the fifo output, so an early fifo reset starves the lock
        assign cnt_src = NEW_GEN ? fifo_reg : in_word;  // R7
        // the sampler steers the tap only once the first lock has been reached
        assign step_up = ever_reg && phase_late[c] && !phase_early[c];
        assign step_dn = ever_reg && phase_early[c] && !phase_late[c];

        // next state of the phase alignment of this channel
        always_comb begin
            tap_next = tap_reg;
            trans_next = trans_reg;
            lock_next = lock_reg;
            ever_next = ever_reg;
            last_dir_next = last_dir_reg;
            stepped_next = stepped_reg;
            last_msb_next = cnt_src[DES_FACTOR-1];
            if (train_rst) begin
                // whole block starts over: tap, count and flag
                tap_next = rx_init_pkg::TAP_RESET;  // R10
                trans_next = '0;
                lock_next = 1'b0;
                ever_next = 1'b0;
                stepped_next = 1'b0;
                last_dir_next = 1'b0;
            end else begin
                trans_next = sat_add(trans_reg, count_edges(cnt_src, last_msb_reg));  // R6
                if (step_up || step_dn) begin
                    // each channel walks its own tap toward the best sample point
                    tap_next = step_up ? tap_reg + 1'b1 : tap_reg - 1'b1;  // R4
                    last_dir_next = step_up;
                    stepped_next = 1'b1;
                end
                if (NEW_GEN) begin
                    // sticky: later tap changes are not shown
                    if (lock_flag_reset[c]) begin  // R9
                        lock_next = 1'b0;
                        trans_next = '0;
                    end else if (trans_reg >= TRANS_W'(TRANS_COUNT)) begin
                        lock_next = 1'b1;  // R9
                    end
                end else begin
                    // old parts drop the flag on a new tap, or with TWO_STEP_UNLOCK on a second step the same way; fifo reset never touches it
                    if ((step_up || step_dn) && (!TWO_STEP_UNLOCK
                        || (stepped_reg && last_dir_reg == step_up))) begin  // R8 R12
                        lock_next = 1'b0;
                        trans_next = '0;
                        stepped_next = 1'b0;
                    end else if (trans_reg >= TRANS_W'(TRANS_COUNT)) begin
                        lock_next = 1'b1;
                    end
                end
                if (lock_reg) begin
                    ever_next = 1'b1;
                end
            end
        end

        // next state of the sync fifo stage; the tap survives a fifo reset
        always_comb begin
            prev_next = fifo_reg;
            if (fifo_clr) begin
                fifo_next = '0;  // R11
                fifo_v_next = 1'b0;
            end else begin
                fifo_next = in_word;
                fifo_v_next = 1'b1;
            end
        end

        // registers of the channel
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                tap_reg <= rx_init_pkg::TAP_RESET;
                trans_reg <= '0;
                lock_reg <= 1'b0;
                ever_reg <= 1'b0;
                last_dir_reg <= 1'b0;
                stepped_reg <= 1'b0;
                last_msb_reg <= 1'b0;
                fifo_reg <= '0;
                prev_reg <= '0;
                fifo_v_reg <= 1'b0;
            end else begin
                tap_reg <= tap_next;
                trans_reg <= trans_next;
                lock_reg <= lock_next;
                ever_reg <= ever_next;
                last_dir_reg <= last_dir_next;
                stepped_reg <= stepped_next;
                last_msb_reg <= last_msb_next;
                fifo_reg <= fifo_next;
                prev_reg <= prev_next;
                fifo_v_reg <= fifo_v_next;
            end
        end

        // word boundary of this channel, steered by its own slip input
        word_slip_aligner #(
            .DES_FACTOR(DES_FACTOR),
            .LIMIT_W(LIMIT_W)
        ) u_slip (
            .ref_clk(ref_clk),
            .rst(rst),
            .pll_locked(pll_ok),
            .slip_reset(slip_reset[c]),
            .slip_pulse(slip_pulse[c]),  // R13
            .slip_limit(slip_limit),
            .cur_word(fifo_reg),
            .prev_word(prev_reg),
            .word_in_valid(fifo_v_reg),
            .word_out(rx_word[c*DES_FACTOR +: DES_FACTOR]),
            .word_out_valid(rx_word_valid[c]),
            .slip_pos(slip_pos[c*LIMIT_W +: LIMIT_W])
        );

        assign dpa_locked[c] = lock_reg;
        assign tap_sel[c*TAP_W +: TAP_W] = tap_reg;
        assign aligned_flag[c] = boundary_found[c] && lock_reg && rx_word_valid[c];
    end

    // ---------------- overall readiness ----------------
    logic ready_reg;  // link usable for normal traffic
    logic ready_next;

    // every channel must hold its boundary; one straggler keeps the link down
    always_comb begin
        ready_next = pll_ok && (&aligned_flag);  // R23
    end

    // readiness register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= ready_next;
        end
    end

    assign link_ready = ready_reg;
endmodule

// ### rtl/rx_init_pkg.sv
package rx_init_pkg;
    // clock period of ref_clk in picoseconds
    localparam int CLK_PERIOD_PS = 5000;
    // least time the pll reset must be held, in nanoseconds
    localparam int PLL_RST_MIN_NS = 10;
    // the same least time in ref_clk cycles, rounded up, never below one
    localparam int PLL_RST_MIN_CYC_RAW = (PLL_RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PLL_RST_MIN_CYC = (PLL_RST_MIN_CYC_RAW < 1) ? 1 : PLL_RST_MIN_CYC_RAW;
    // width of the counter that measures the pll reset pulse
    localparam int RST_LEN_W = 8;
    // default cycles from pll reset release to lock
    localparam int PLL_LOCK_CYCLES_DEF = 64;
    // default data transitions seen before phase lock
    localparam int TRANS_COUNT_DEF = 256;
    // width of the transition counter
    localparam int TRANS_W = 16;
    // width of the phase tap selector
    localparam int TAP_W = 3;
    // tap chosen after a phase-alignment reset
    localparam logic [TAP_W-1:0] TAP_RESET = 3'h0;
    // default deserialization factor
    localparam int DES_FACTOR_DEF = 8;
    // default number of receiver channels
    localparam int NUM_CH_DEF = 4;
    // pll lock model states
    typedef enum logic [1:0] {
        PLL_IN_RESET,
        PLL_ACQUIRE,
        PLL_LOCKED,
        PLL_BAD_RESET
    } pll_state_t;
endpackage

// ### rtl/word_slip_aligner.sv
`timescale 1ns/1ps
// per-channel bit-slip circuit: moves the word boundary one bit per slip pulse
module word_slip_aligner #(
    parameter int DES_FACTOR = rx_init_pkg::DES_FACTOR_DEF,
    parameter int LIMIT_W = $clog2(DES_FACTOR) + 2
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic pll_locked,
    input wire logic slip_reset,
    input wire logic slip_pulse,
    input wire logic [LIMIT_W-1:0] slip_limit,
    input wire logic [DES_FACTOR-1:0] cur_word,
    input wire logic [DES_FACTOR-1:0] prev_word,
    input wire logic word_in_valid,
    output logic [DES_FACTOR-1:0] word_out,
    output logic word_out_valid,
    output logic [LIMIT_W-1:0] slip_pos
);
    logic [LIMIT_W-1:0] pos_reg;  // current slip position
    logic [LIMIT_W-1:0] pos_next;
    logic pulse_d_reg;  // last slip input, for edge detection
    logic pulse_d_next;
    logic [DES_FACTOR-1:0] out_reg;  // aligned word
    logic [DES_FACTOR-1:0] out_next;
    logic valid_reg;  // aligned word holds data
    logic valid_next;

    // bit offset inside one word; positions past the factor wrap within the word
    function automatic int unsigned bit_offset(input logic [LIMIT_W-1:0] pos);
        bit_offset = int'(pos) % DES_FACTOR;
    endfunction

    // window of one word taken from the two latest words at a given offset
    function automatic logic [DES_FACTOR-1:0] window(
        input logic [DES_FACTOR-1:0] hi,
        input logic [DES_FACTOR-1:0] lo,
        input int unsigned off
    );
        logic [2*DES_FACTOR-1:0] both;
        both = {hi, lo} >> off;
        window = both[DES_FACTOR-1:0];
    endfunction

    // next slip position and aligned word
    always_comb begin
        pulse_d_next = slip_pulse;
        pos_next = pos_reg;
        // own reset works at any moment, regardless of pll or phase state
        if (slip_reset) begin  // R14
            pos_next = '0;
        end else if (!pll_locked) begin
            // default boundary restarts with the pll, deterministic only at ref = rate/factor
            pos_next = '0;  // R17
        end else if (slip_pulse && !pulse_d_reg) begin
            // one rising edge moves exactly one serial bit; a held level counts once
            if (pos_reg + 1'b1 >= slip_limit) begin  // R24
                pos_next = '0;
            end else begin
                pos_next = pos_reg + 1'b1;  // R13
            end
        end
        out_next = window(cur_word, prev_word, bit_offset(pos_reg));
        valid_next = word_in_valid && pll_locked;
    end

    // registers only
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pos_reg <= '0;
            pulse_d_reg <= 1'b0;
            out_reg <= '0;
            valid_reg <= 1'b0;
        end else begin
            pos_reg <= pos_next;
            pulse_d_reg <= pulse_d_next;
            out_reg <= out_next;
            valid_reg <= valid_next;
        end
    end

    assign word_out = out_reg;
    assign word_out_valid = valid_reg;
    assign slip_pos = pos_reg;
endmodule

// ### tb/host_fabric_model.sv
`timescale 1ns/1ps
// fabric side of bring-up: walks the resets in order, promptly or slowly
module host_fabric_model #(
    parameter int NUM_CH = 4,
    parameter int STABLE_CYC = 3
) (
    input wire logic ref_clk,
    input wire logic start,
    input wire logic slow,
    input wire logic pll_locked,
    input wire logic [NUM_CH-1:0] dpa_locked,
    output logic pll_reset,
    output logic [NUM_CH-1:0] dpa_reset,
    output logic [NUM_CH-1:0] fifo_reset,
    output logic [NUM_CH-1:0] slip_reset,
    output logic done
);
    int n; // edges the pll lock has stayed high
    initial begin
        pll_reset = 1'b0;
        dpa_reset = '1;
        fifo_reset = '0;
        slip_reset = '0;
        done = 1'b0;
    end
    // one full bring-up per rising edge of start
    always @(posedge start) begin
        done = 1'b0;
        @(posedge ref_clk);
        #1 pll_reset = 1'b1;
        dpa_reset = '1;
        repeat (rx_init_pkg::PLL_RST_MIN_CYC + (slow ? 3 : 0)) @(posedge ref_clk);
        #1 pll_reset = 1'b0;
        n = 0;
        // lock must stay up a while before it counts as stable
        while (n < STABLE_CYC) begin
            @(posedge ref_clk);
            n = pll_locked ? n + 1 : 0;
        end
        #1 dpa_reset = '0;
        while (dpa_locked !== '1) @(posedge ref_clk);
        #1 fifo_reset = '1;
        @(posedge ref_clk);
        #1 fifo_reset = '0;
        slip_reset = '1;
        @(posedge ref_clk);
        #1 slip_reset = '0;
        done = 1'b1;
    end
endmodule

// ### tb/rx_init_align_bench.sv
`timescale 1ns/1ps
// bring-up, slip and readiness checks against an integer model
module rx_init_align_bench;
    localparam int NC = 2; // two lanes keep the run short
    localparam int F = 8;
    localparam int LW = 5;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic slow = 1'b0;
    logic rnd_slip = 1'b0;
    logic rnd_ph = 1'b0;
    logic short_pll = 1'b0; // extra one-cycle pll pulse
    logic pll_reset, pll_locked, pll_reset_short, link_ready, done;
    logic [NC-1:0] dpa_reset, fifo_reset, slip_reset, dpa_locked, rx_word_valid;
    logic [NC-1:0] flag_rst = '0, slip_pulse = '0, early = '0, late = '0, found = '0;
    logic [NC-1:0] tb_fifo = '0, tb_srst = '0, v_q = '0; // v_q: valid at last check
    logic [NC-1:0] srst;
    logic [LW-1:0] slip_limit = 5'h08;
    logic [LW-1:0] lims[4] = '{5'h08, 5'h03, 5'h09, 5'h00};
    logic [NC*F-1:0] serial_word = '0, rx_word;
    logic [NC*3-1:0] tap_sel;
    logic [NC*LW-1:0] slip_pos;
    logic [2:0] tap_keep;
    int seed = 32'h0a2e;
    int n_fail = 0, n_tests = 0;
    int pos[NC] = '{0, 0}, pos_q[NC];
    logic sp_q[NC] = '{1'b0, 1'b0};
    logic [NC*F-1:0] wq[$]; // sampled words, newest first
    assign srst = slip_reset | tb_srst;
    always #2.5 ref_clk = ~ref_clk;
    rx_init_align #(.NUM_CH(NC), .PLL_LOCK_CYCLES(4), .TRANS_COUNT(16)) u_dut (
        .*, .pll_reset(pll_reset | short_pll), .lock_flag_reset(flag_rst),
        .fifo_reset(fifo_reset | tb_fifo), .slip_reset(srst), .phase_early(early),
        .phase_late(late), .boundary_found(found));
    host_fabric_model #(.NUM_CH(NC)) u_host (.*);
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // random traffic, slips and hints, one small delay after each edge
    always @(posedge ref_clk) begin
        #1 serial_word = (NC*F)'($random(seed));
        slip_pulse = rnd_slip ? NC'($random(seed)) : '0;
        tb_srst = (rnd_slip && ($random(seed) & 7) == 0) ? 2'h1 : 2'h0;
        early = rnd_ph ? NC'($random(seed)) : '0;
        late = rnd_ph ? NC'($random(seed)) : '0;
    end
    // model: slip counter per lane and the two-edge word path at offset 0
    always @(posedge ref_clk) begin
        for (int c = 0; c < NC; c++) begin
            pos_q[c] = pos[c];
            if (rst || srst[c] || !pll_locked) pos[c] = 0;
            else if (slip_pulse[c] && !sp_q[c]) pos[c] = (pos[c] + 1 >= slip_limit) ? 0 : pos[c] + 1;
            sp_q[c] = slip_pulse[c];
        end
        wq.push_front(serial_word);
        if (wq.size() > 3) void'(wq.pop_back());
        #2;
        for (int c = 0; c < NC; c++) begin
            chk("slip_pos", 16'(pos[c]), 16'(slip_pos[c*LW +: LW]));
            // the first word after a fifo clear pairs with a cleared older word: skip it
            if (rx_word_valid[c] === 1'b1 && v_q[c] && pos_q[c] == 0 && wq.size() == 3)
                chk("rx_word", 16'(wq[2][c*F +: F]), 16'(rx_word[c*F +: F]));
        end
        v_q = rx_word_valid;
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        #1 rst = 1'b0;
        chk("link_ready", 16'h0, 16'(link_ready));
        repeat (3) @(posedge ref_clk);
        #1 short_pll = 1'b1;
        @(posedge ref_clk);
        #1 short_pll = 1'b0;
        repeat (12) @(posedge ref_clk);
        #1 chk("pll_locked", 16'h0, 16'(pll_locked));
        chk("pll_reset_short", 16'h1, 16'(pll_reset_short));
        // bring-up twice: prompt, then with the fabric stalling
        for (int s = 0; s < 2; s++) begin
            slow = s[0];
            start = 1'b1;
            @(posedge ref_clk);
            #1 start = 1'b0;
            // a hang here is caught by the watchdog
            while (done !== 1'b1) @(posedge ref_clk);
            #1 chk("dpa_locked", 16'h3, 16'(dpa_locked));
        end
        @(posedge ref_clk);
        rnd_ph = 1'b1;
        repeat (20) @(posedge ref_clk);
        rnd_ph = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 tap_keep = tap_sel[2:0];
        tb_fifo = 2'h3;
        repeat (3) @(posedge ref_clk);
        #1 tb_fifo = '0;
        chk("tap_sel", 16'(tap_keep), 16'(tap_sel[2:0]));
        chk("dpa_locked", 16'h3, 16'(dpa_locked));
        flag_rst = 2'h2;
        @(posedge ref_clk);
        #1 flag_rst = '0;
        chk("dpa_locked", 16'h1, 16'(dpa_locked));
        repeat (20) @(posedge ref_clk);
        #1 chk("dpa_locked", 16'h3, 16'(dpa_locked));
        // limits below, at and above the word size, and zero
        foreach (lims[i]) begin
            #1 slip_limit = lims[i];
            rnd_slip = 1'b1;
            repeat (40) @(posedge ref_clk);
        end
        rnd_slip = 1'b0;
        #1 found = 2'h1;
        repeat (3) @(posedge ref_clk);
        #1 chk("link_ready", 16'h0, 16'(link_ready));
        found = 2'h3;
        repeat (3) @(posedge ref_clk);
        #1 chk("link_ready", 16'h1, 16'(link_ready));
        tally_and_finish();
    end
    // a hang counts as a mismatch
    initial begin
        #25000;
        n_fail++;
        tally_and_finish();
    end
endmodule

// ### tb/rx_init_align_checker.sv
`timescale 1ns/1ps
// lane 0 stands for every lane; the lanes share one piece of logic
module rx_init_align_checker #(
    parameter int NUM_CH = 4,
    parameter int LIMIT_W = 5
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic pll_reset,
    input wire logic [NUM_CH-1:0] dpa_reset,
    input wire logic [NUM_CH-1:0] lock_flag_reset,
    input wire logic [NUM_CH-1:0] fifo_reset,
    input wire logic [NUM_CH-1:0] slip_reset,
    input wire logic [NUM_CH-1:0] slip_pulse,
    input wire logic [LIMIT_W-1:0] slip_limit,
    input wire logic [NUM_CH-1:0] boundary_found,
    input wire logic pll_locked,
    input wire logic [NUM_CH-1:0] dpa_locked,
    input wire logic [NUM_CH*rx_init_pkg::TAP_W-1:0] tap_sel,
    input wire logic [NUM_CH-1:0] rx_word_valid,
    input wire logic [NUM_CH*LIMIT_W-1:0] slip_pos,
    input wire logic link_ready
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // one spare bit so the wrap sum cannot overflow
    logic [LIMIT_W:0] pos0;
    assign pos0 = {1'b0, slip_pos[LIMIT_W-1:0]};
    a_pll_drop: assert property (pll_reset |=> !pll_locked)
        else $error("pll lock kept in reset");
    // lock count of 4 matches the bench build
    a_lock_time: assert property ($fell(pll_reset) && $past(pll_reset, 2)
        ##1 !pll_reset [*4] |-> !pll_locked ##1 pll_locked)
        else $error("pll lock time wrong");
    a_short_refused: assert property ($fell(pll_reset) && !$past(pll_reset, 2)
        ##1 !pll_reset [*6] |-> !pll_locked)
        else $error("locked after short reset");
    a_slip_step: assert property ($rose(slip_pulse[0]) && !slip_reset[0]
        && pll_locked && !pll_reset
        |=> pos0 == (($past(pos0) + 1 >= $past(slip_limit)) ? 0 : $past(pos0) + 1))
        else $error("slip step or wrap wrong");
    a_slip_hold: assert property (!$rose(slip_pulse[0]) && !slip_reset[0]
        && pll_locked && !pll_reset |=> $stable(pos0))
        else $error("slip moved with no pulse");
    a_slip_clear: assert property (slip_reset[0] |=> pos0 == 0)
        else $error("slip reset not cleared");
    a_dpa_clear: assert property (dpa_reset[0] |=> !dpa_locked[0]
        && tap_sel[rx_init_pkg::TAP_W-1:0] == rx_init_pkg::TAP_RESET)
        else $error("phase reset left lock or tap");
    a_flag_clear: assert property (lock_flag_reset[0] |=> !dpa_locked[0])
        else $error("lock flag reset ignored");
    a_fifo_keep: assert property (fifo_reset[0] && dpa_locked[0] && !dpa_reset[0]
        && !lock_flag_reset[0] && !pll_reset && pll_locked |=> dpa_locked[0])
        else $error("fifo reset dropped phase lock");
    a_ready_cause: assert property (link_ready ==
        $past(pll_locked && (&(boundary_found & dpa_locked & rx_word_valid))))
        else $error("link ready cause wrong");
endmodule
bind rx_init_align rx_init_align_checker #(.NUM_CH(NUM_CH), .LIMIT_W(LIMIT_W)) u_chk (.*);
